/* src/sbc_consts.svh */
// named constants for the diagnostic encoder and spi response logic
// assumes a 16 bit frame, lsb first, mode bits sent first
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// frame layout
`define SBC_FRAME_BITS 16
`define SBC_CNT_W 5
`define SBC_HDR_BITS 5'h06
`define SBC_FULL_CNT 5'h10

// mode selection codes, as sent and reported
`define SBC_MS_NORMAL 3'h0
`define SBC_MS_SLEEP 3'h1
`define SBC_MS_FAILSAFE 3'h2
`define SBC_MS_RESTART 3'h3
`define SBC_MS_INIT 3'h4
`define SBC_MS_READ_ONLY 3'h7

// configuration select codes
`define SBC_SEL_WAKE 3'h0
`define SBC_SEL_CONFIG 3'h4
`define SBC_SEL_WDOG 3'h6
`define SBC_SEL_DIAG 3'h7

// configuration register fields and reset value
`define SBC_CFG_RST 9'h115
`define SBC_CFG_LH_BIT 6
`define SBC_CFG_ESC_BIT 8
`define SBC_THR_INVALID 2'h0
`define SBC_THR_RST 2'h1

// watchdog register fields and reset value
`define SBC_WD_RST 9'h1EF
`define SBC_WD_CHK_BIT 8
`define SBC_WD_SPLIT 5'h10
`define SBC_WD_LO_STEP 11'h010
`define SBC_WD_HI_STEP 11'h030
`define SBC_WD_HI_OFS 11'h1D0
`define SBC_WD_PERIOD_RST 11'h100

// diagnostic codes
`define SBC_RR_NONE 2'h0
`define SBC_LC_NONE 3'h0
`define SBC_LC_ONE_WD 3'h2
`define SBC_LC_TWO_WD 3'h3
`define SBC_HW_DEV_BIT 2

`endif

/* src/sbc_pkg.sv */
// types shared by the diagnostic encoder and spi response logic
// writes its numeric values out itself; they must agree with sbc_consts.svh
package sbc_pkg;

    // reset threshold selector as decoded
    typedef enum logic [1:0] {
        SBC_THR_ONE = 2'h1,
        SBC_THR_TWO = 2'h2,
        SBC_THR_THREE = 2'h3
    } sbc_thr_t;

    // one spi frame, lsb transmitted first
    typedef struct packed {
        logic [9:0] data;
        logic [2:0] sel;
        logic [2:0] ms;
    } sbc_frame_t;

    // latched diagnostics as read back
    typedef struct packed {
        logic [2:0] hw_config;
        logic [2:0] limp_cause;
        logic [1:0] restart_reason;
    } sbc_diag_t;

endpackage

/* src/sbc_sync.sv */
// two flip-flop synchroniser for one signal from outside the clock domain
// assumes the source is slow against i_clk
`timescale 1ns/1ns
module sbc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // async level in, synchronised level out
    input wire logic i_async,
    output logic o_sync
);
    logic meta_r;

    // first stage is read only by the second
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

/* src/sbc_wd_decode.sv */
// watchdog period decoder, setting n to period in milliseconds
// assumes a five bit setting; purely combinational
`include "sbc_consts.svh"
`timescale 1ns/1ns
module sbc_wd_decode (
    // setting in
    input wire logic [4:0] i_setting,
    // period out in ms
    output logic [10:0] o_period_ms
);
    // two linear segments meet at n = 15 / 16
    always_comb begin
        if (i_setting < `SBC_WD_SPLIT) begin
            o_period_ms = ({6'h00, i_setting} + 11'h001) * `SBC_WD_LO_STEP;
        end else begin
            o_period_ms = {6'h00, i_setting} * `SBC_WD_HI_STEP
                          - `SBC_WD_HI_OFS;
        end
    end
endmodule

/* src/sbc_spi_diag_encoders.sv */
// spi frame engine, setting decoders and diagnostic encoders
// assumes spi mode 0 from the host, sclk well below i_clk / 6
`include "sbc_consts.svh"
`timescale 1ns/1ns
module sbc_spi_diag_encoders (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // spi pins
    input wire logic i_spi_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    // mode context from the state machine
    input wire logic [2:0] i_cur_mode,
    input wire logic i_normal_entry,
    input wire logic [2:0] i_prev_mode,
    input wire logic i_prev_fail,
    input wire logic i_leave_sleep_fs,
    // diagnostic events
    input wire logic i_rst_evt,
    input wire logic [1:0] i_rst_code,
    input wire logic i_lh_evt,
    input wire logic [2:0] i_lh_code,
    input wire logic i_wd_fail,
    // hardware configuration strap pins
    input wire logic [2:0] i_hw_config,
    // read data of registers held elsewhere
    input wire logic [9:0] i_ext_rd_data,
    // decoded settings
    output sbc_pkg::sbc_thr_t o_threshold,
    output logic [10:0] o_wd_period_ms,
    output logic o_limp_home_output,
    output logic o_sw_dev_mode,
    // diagnostics
    output logic [1:0] o_restart_reason,
    output logic [2:0] o_limp_cause,
    // command pulses and their held arguments
    output logic o_wd_trigger,
    output logic o_wd_restart_req,
    output logic o_limp_req,
    output logic o_ro_clear,
    output logic [2:0] o_ro_clear_sel,
    output logic o_write,
    output sbc_pkg::sbc_frame_t o_write_frame
);
    import sbc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_EXEC = 3'b100
    } sbc_state_t;

    sbc_state_t state_r;
    logic s_sclk, s_csn, s_sdi, sclk_d_r, csn_d_r;
    logic sclk_rise, sclk_fall, csn_fall, csn_rise;
    logic [2:0] s_hw;
    logic [`SBC_CNT_W-1:0] cnt_r;
    logic [`SBC_FRAME_BITS-1:0] rx_r, tx_r;
    sbc_frame_t frm, rx_nxt, hdr_frm;
    logic [8:0] cfg_r, wd_r;
    logic [2:0] resp_sel_r, prev_ms_r;
    logic first_r;
    logic [1:0] fail_cnt_r, fail_need;
    logic [10:0] period_c;
    logic parity_ok, exec_ro, exec_wr, limp_fire;
    sbc_diag_t diag;
    sbc_frame_t resp_word;

    // pins cross into i_clk before anything looks at them
    sbc_sync #(.RST_VAL(1'b0)) u_sync_sclk (.i_clk(i_clk), .i_srst(i_srst),
        .i_ce(i_ce), .i_async(i_spi_sclk), .o_sync(s_sclk));
    sbc_sync #(.RST_VAL(1'b1)) u_sync_csn (.i_clk(i_clk), .i_srst(i_srst),
        .i_ce(i_ce), .i_async(i_chip_select_n), .o_sync(s_csn));
    sbc_sync #(.RST_VAL(1'b0)) u_sync_sdi (.i_clk(i_clk), .i_srst(i_srst),
        .i_ce(i_ce), .i_async(i_spi_sdi), .o_sync(s_sdi));
    generate
        for (genvar g = 0; g < 3; g++) begin : g_hw
            sbc_sync #(.RST_VAL(1'b0)) u_sync_hw (.i_clk(i_clk),
                .i_srst(i_srst), .i_ce(i_ce), .i_async(i_hw_config[g]),
                .o_sync(s_hw[g]));
        end
    endgenerate

    sbc_wd_decode u_wd_decode (.i_setting(wd_r[4:0]),
        .o_period_ms(period_c));

    // edge finding on synchronised levels
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sclk_d_r <= 1'b0;
            csn_d_r <= 1'b1;
        end else if (i_ce) begin
            sclk_d_r <= s_sclk;
            csn_d_r <= s_csn;
        end
    end
    assign sclk_rise = s_sclk & ~sclk_d_r & ~s_csn;
    assign sclk_fall = ~s_sclk & sclk_d_r & ~s_csn;
    assign csn_fall = ~s_csn & csn_d_r;
    assign csn_rise = s_csn & ~csn_d_r;

    // decoded frame and derived terms
    assign rx_nxt = sbc_frame_t'({s_sdi, rx_r[`SBC_FRAME_BITS-1:1]});
    // mid-frame the header sits in the top bits, not at the frame's lsb
    assign hdr_frm = sbc_frame_t'({s_sdi, rx_r[`SBC_FRAME_BITS-1:1]}
                                  >> (`SBC_FRAME_BITS - `SBC_HDR_BITS));
    assign frm = sbc_frame_t'(rx_r);
    assign parity_ok = (frm.data[`SBC_WD_CHK_BIT] == ^frm.data[7:0]);
    assign exec_ro = (state_r == ST_EXEC) && (frm.ms == `SBC_MS_READ_ONLY);
    assign exec_wr = (state_r == ST_EXEC) && (frm.ms != `SBC_MS_READ_ONLY);
    assign diag = '{hw_config: s_hw, limp_cause: o_limp_cause,
                    restart_reason: o_restart_reason};
    assign fail_need = cfg_r[`SBC_CFG_ESC_BIT] ? 2'h2 : 2'h1;
    assign limp_fire = i_wd_fail && ((fail_cnt_r + 2'h1) >= fail_need);

    // register read mux by configuration select
    function automatic logic [9:0] rd_data(input logic [2:0] sel);
        case (sel)
            `SBC_SEL_CONFIG: rd_data = {1'b0, cfg_r};
            `SBC_SEL_WDOG: rd_data = {1'b0, wd_r};
            `SBC_SEL_DIAG: rd_data = {2'h0, diag};
            default: rd_data = i_ext_rd_data;
        endcase
    endfunction

    // answer prepared for the next frame; first frame shows previous mode
    assign resp_word = '{data: rd_data(resp_sel_r), sel: resp_sel_r,
        ms: first_r ? prev_ms_r : i_cur_mode};

    // frame sequencer; a short frame is dropped at chip select release
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            rx_r <= '0;
        end else if (i_ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (csn_fall) begin
                        state_r <= ST_SHIFT;
                        cnt_r <= '0;
                    end
                end
                ST_SHIFT: begin
                    if (csn_rise) begin
                        state_r <= (cnt_r == `SBC_FULL_CNT) ? ST_EXEC
                                                            : ST_IDLE;
                    end else if (sclk_rise && cnt_r != `SBC_FULL_CNT) begin
                        rx_r <= rx_nxt;
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                ST_EXEC: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // serial out; read-only swaps the data part once the header is in
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_r <= '0;
            o_spi_sdo <= 1'b0;
            o_spi_sdo_oe <= 1'b0;
        end else if (i_ce) begin
            o_spi_sdo_oe <= ~s_csn;
            if (state_r == ST_IDLE && csn_fall) begin
                o_spi_sdo <= resp_word[0];
                tx_r <= {1'b0, resp_word[`SBC_FRAME_BITS-1:1]};
            end else if (state_r == ST_SHIFT && sclk_rise &&
                         cnt_r == `SBC_HDR_BITS - 5'h01 &&
                         hdr_frm.ms == `SBC_MS_READ_ONLY) begin
                tx_r <= {6'h00, rd_data(hdr_frm.sel)};
            end else if (state_r == ST_SHIFT && sclk_fall) begin
                o_spi_sdo <= tx_r[0];
                tx_r <= {1'b0, tx_r[`SBC_FRAME_BITS-1:1]};
            end
        end
    end

    // response selection for the next frame
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            resp_sel_r <= `SBC_SEL_CONFIG;
            prev_ms_r <= `SBC_MS_INIT;
            first_r <= 1'b1;
        end else if (i_ce) begin
            if (i_normal_entry) begin
                first_r <= 1'b1;
                prev_ms_r <= i_prev_mode;
                case (i_prev_mode)
                    `SBC_MS_SLEEP: resp_sel_r <= `SBC_SEL_WAKE;
                    `SBC_MS_FAILSAFE: resp_sel_r <= `SBC_SEL_DIAG;
                    `SBC_MS_RESTART: resp_sel_r <= i_prev_fail ?
                        `SBC_SEL_DIAG : `SBC_SEL_CONFIG;
                    default: resp_sel_r <= `SBC_SEL_CONFIG;
                endcase
            end else if (state_r == ST_EXEC) begin
                first_r <= 1'b0;
                resp_sel_r <= frm.sel;
            end
        end
    end

    // configuration and watchdog registers; read-only leaves them alone
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg_r <= `SBC_CFG_RST;
            wd_r <= `SBC_WD_RST;
        end else if (i_ce) begin
            if (exec_wr && frm.sel == `SBC_SEL_CONFIG) begin
                cfg_r[8:2] <= frm.data[8:2];
                if (frm.data[1:0] != `SBC_THR_INVALID) begin
                    cfg_r[1:0] <= frm.data[1:0];
                end
            end
            if (exec_wr && frm.sel == `SBC_SEL_WDOG && parity_ok) begin
                wd_r <= frm.data[8:0];
            end
        end
    end

    // decoded settings registered onto the outputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_threshold <= SBC_THR_ONE;
            o_wd_period_ms <= `SBC_WD_PERIOD_RST;
            o_sw_dev_mode <= 1'b0;
        end else if (i_ce) begin
            o_threshold <= sbc_thr_t'(cfg_r[1:0]);
            o_wd_period_ms <= period_c;
            o_sw_dev_mode <= s_hw[`SBC_HW_DEV_BIT];
        end
    end

    // command pulses of one cycle each, with the clear select and write frame held between them
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_wd_trigger <= 1'b0;
            o_ro_clear <= 1'b0;
            o_ro_clear_sel <= '0;
            o_write <= 1'b0;
            o_write_frame <= '0;
        end else if (i_ce) begin
            o_wd_trigger <= exec_ro || (exec_wr && frm.sel == `SBC_SEL_WDOG
                                        && parity_ok);
            o_ro_clear <= exec_ro;
            o_ro_clear_sel <= exec_ro ? frm.sel : o_ro_clear_sel;
            o_write <= exec_wr && !(frm.sel == `SBC_SEL_WDOG && !parity_ok);
            o_write_frame <= exec_wr ? frm : o_write_frame;
        end
    end

    // restart reason latch; a new event wins over any clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_restart_reason <= `SBC_RR_NONE;
        end else if (i_ce) begin
            if (i_rst_evt) begin
                o_restart_reason <= i_rst_code;
            end else if (i_leave_sleep_fs) begin
                o_restart_reason <= `SBC_RR_NONE;
            end else if (exec_ro && frm.sel == `SBC_SEL_DIAG) begin
                o_restart_reason <= `SBC_RR_NONE;
            end
        end
    end

    // failure escalation; development mode keeps the host supply running
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fail_cnt_r <= 2'h0;
            o_limp_req <= 1'b0;
            o_wd_restart_req <= 1'b0;
        end else if (i_ce) begin
            o_limp_req <= limp_fire;
            o_wd_restart_req <= i_wd_fail && !s_hw[`SBC_HW_DEV_BIT];
            if (limp_fire || o_wd_trigger) begin
                fail_cnt_r <= 2'h0;
            end else if (i_wd_fail) begin
                fail_cnt_r <= fail_cnt_r + 2'h1;
            end
        end
    end

    // limp home output and cause; an event wins over switching off
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_limp_cause <= `SBC_LC_NONE;
            o_limp_home_output <= 1'b0;
        end else if (i_ce) begin
            if (limp_fire) begin
                o_limp_cause <= cfg_r[`SBC_CFG_ESC_BIT] ? `SBC_LC_TWO_WD
                                                        : `SBC_LC_ONE_WD;
                o_limp_home_output <= 1'b1;
            end else if (i_lh_evt) begin
                o_limp_cause <= i_lh_code;
                o_limp_home_output <= 1'b1;
            end else if (exec_wr && frm.sel == `SBC_SEL_CONFIG) begin
                o_limp_home_output <= frm.data[`SBC_CFG_LH_BIT];
                if (!frm.data[`SBC_CFG_LH_BIT]) begin
                    o_limp_cause <= `SBC_LC_NONE;
                end
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_thr_invalid_keep: assert property (i_ce && exec_wr &&
        frm.sel == `SBC_SEL_CONFIG && frm.data[1:0] == `SBC_THR_INVALID
        |=> $stable(cfg_r[1:0]))
        else $error("threshold changed on invalid code");
    chk_wd_period_map: assert property (i_ce && !$past(i_srst)
        && wd_r[4:0] == 5'h0F |=> o_wd_period_ms == 11'h100)
        else $error("default watchdog period wrong");
    chk_ro_clears_reason: assert property (i_ce && exec_ro &&
        frm.sel == `SBC_SEL_DIAG && !i_rst_evt
        |=> o_restart_reason == `SBC_RR_NONE)
        else $error("restart reason not cleared by read");
    chk_lh_off_cause: assert property (i_ce && exec_wr &&
        frm.sel == `SBC_SEL_CONFIG && !frm.data[`SBC_CFG_LH_BIT]
        && !limp_fire && !i_lh_evt |=> o_limp_cause == `SBC_LC_NONE
        && !o_limp_home_output)
        else $error("limp cause kept after switch off");
    chk_dev_no_restart: assert property (i_ce && i_wd_fail &&
        s_hw[`SBC_HW_DEV_BIT] |=> !o_wd_restart_req)
        else $error("restart requested in development mode");
    chk_first_no_clear: assert property (i_ce && first_r
        && !exec_ro && !i_rst_evt && !i_leave_sleep_fs
        |=> $stable(o_restart_reason))
        else $error("first frame cleared latched bits");
    chk_ro_no_write: assert property (i_ce && exec_ro
        |=> !o_write && $stable(cfg_r) && $stable(wd_r))
        else $error("read-only command wrote");
    chk_ro_wd_trigger: assert property (i_ce && exec_ro
        |=> o_wd_trigger && o_ro_clear)
        else $error("read-only did not trigger watchdog");
    chk_parity_reject: assert property (i_ce && exec_wr &&
        frm.sel == `SBC_SEL_WDOG && !parity_ok |=> $stable(wd_r)
        && !o_wd_trigger)
        else $error("bad parity write accepted");
    chk_short_frame: assert property (i_ce && state_r == ST_SHIFT
        && csn_rise && cnt_r != `SBC_FULL_CNT |=> state_r == ST_IDLE)
        else $error("short frame executed");
    chk_limp_single: assert property (i_ce && i_wd_fail &&
        !cfg_r[`SBC_CFG_ESC_BIT] |=> o_limp_req && o_limp_home_output)
        else $error("no limp home after one failure");
endmodule

/* test/sbc_host_model.sv */
// host spi controller model: mode 0, lsb first, 320 ns sclk period
// assumes the testbench calls xfer and leaves a gap between frames
`timescale 1ns/1ns
module sbc_host_model (
    // spi pins
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdi,
    input wire logic i_sdo
);
    // idle at the pull levels: csn up, sclk and sdi down
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
    end

    // one whole frame; sclk stands still outside it
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        o_csn = 1'b0;
        #160;
        for (int i = 0; i < 16; i++) begin
            o_sdi = tx[i]; // lsb first
            #160 o_sclk = 1'b1;
            rx[i] = i_sdo;
            #160 o_sclk = 1'b0;
        end
        #280 o_csn = 1'b1;
        o_sdi = 1'b0; // released line falls to its pull-down
    endtask
endmodule

/* test/sbc_spi_diag_encoders_test.sv */
// testbench for the spi diagnostic encoder block
// assumes sbc_host_model drives the spi pins
`include "sbc_consts.svh"
`timescale 1ns/1ns
module sbc_spi_diag_encoders_test;
    import sbc_pkg::*;
    logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1;
    logic i_spi_sclk, i_chip_select_n, i_spi_sdi, o_spi_sdo, o_spi_sdo_oe;
    logic [2:0] i_cur_mode = 3'h0, i_prev_mode = 3'h0;
    logic [2:0] i_lh_code = 3'h0, i_hw_config = 3'h0;
    logic i_normal_entry = 1'b0, i_prev_fail = 1'b0, i_wd_fail = 1'b0;
    logic i_leave_sleep_fs = 1'b0, i_rst_evt = 1'b0, i_lh_evt = 1'b0;
    logic [1:0] i_rst_code = 2'h0, o_restart_reason;
    logic [9:0] i_ext_rd_data = 10'h2A5;
    sbc_thr_t o_threshold;
    logic [10:0] o_wd_period_ms;
    logic o_limp_home_output, o_sw_dev_mode, o_wd_trigger, o_write;
    logic o_wd_restart_req, o_limp_req, o_ro_clear;
    logic [2:0] o_limp_cause, o_ro_clear_sel;
    sbc_frame_t o_write_frame;
    int bad_count = 0, checks_done = 0, n_rst = 0, n_limp = 0, n_trig = 0;

    sbc_spi_diag_encoders dut_u (.i_clk, .i_srst, .i_ce, .i_spi_sclk,
        .i_chip_select_n, .i_spi_sdi, .o_spi_sdo, .o_spi_sdo_oe,
        .i_cur_mode, .i_normal_entry, .i_prev_mode, .i_prev_fail,
        .i_leave_sleep_fs, .i_rst_evt, .i_rst_code, .i_lh_evt, .i_lh_code,
        .i_wd_fail, .i_hw_config, .i_ext_rd_data, .o_threshold,
        .o_wd_period_ms, .o_limp_home_output, .o_sw_dev_mode,
        .o_restart_reason, .o_limp_cause, .o_wd_trigger, .o_wd_restart_req,
        .o_limp_req, .o_ro_clear, .o_ro_clear_sel, .o_write, .o_write_frame);
    sbc_host_model host_u (.o_sclk(i_spi_sclk), .o_csn(i_chip_select_n),
        .o_sdi(i_spi_sdi), .i_sdo(o_spi_sdo));

    always #20 i_clk = ~i_clk;

    // count one-cycle command pulses so no task has to catch them live
    always @(negedge i_clk) begin
        if (o_wd_restart_req === 1'b1) n_rst <= n_rst + 1;
        if (o_limp_req === 1'b1) n_limp <= n_limp + 1;
        if (o_wd_trigger === 1'b1) n_trig <= n_trig + 1;
    end

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [15:0] mk(logic [2:0] m, s, logic [9:0] d);
        return {d, s, m};
    endfunction

    // a frame, then a bounded wait for its execution pulse
    task automatic fr(logic [15:0] tx, bit ex, output logic [15:0] rx);
        host_u.xfer(tx, rx);
        chk("oe_frame", 1, o_spi_sdo_oe);
        for (int n = 0; n < 30; n++) begin
            @(negedge i_clk);
            if (ex && (o_write | o_ro_clear | o_wd_trigger) === 1'b1) break;
            if (ex && n == 29) begin
                bad_count++;
                wrap_up();
            end
        end
        repeat (2) @(negedge i_clk);
        chk("oe_idle", 0, o_spi_sdo_oe);
    endtask

    task automatic pulse(ref logic s);
        @(negedge i_clk);
        s = 1'b1;
        @(negedge i_clk);
        s = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic t_thr;
        logic [1:0] cd [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
        logic [1:0] ex [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
        logic [15:0] rx;
        chk("thr_rst", SBC_THR_ONE, o_threshold);
        chk("wd_rst", `SBC_WD_PERIOD_RST, o_wd_period_ms);
        for (int i = 0; i < 4; i++) begin
            fr(mk(3'h0, 3'h4, {8'h45, cd[i]}), 1'b1, rx);
            chk("thr", ex[i], o_threshold);
            if (i == 1 || i == 2) begin
                chk("next", {8'h45, cd[i-1], 3'h4}, rx[15:3]);
                chk("hdr_ms", `SBC_MS_NORMAL, rx[2:0]);
            end
        end
        $display("test threshold done");
    endtask

    task automatic t_wd;
        int ns [6] = '{0, 1, 15, 16, 17, 31};
        logic [15:0] rx;
        logic [7:0] d;
        int e;
        for (int i = 0; i < 6; i++) begin
            d = {3'h7, 5'(ns[i])};
            e = ns[i] < 16 ? (ns[i] + 1) * 16 : ns[i] * 48 - 464;
            fr(mk(3'h0, 3'h6, {1'b0, ^d, d}), 1'b1, rx);
            chk("wd_period", 16'(e), o_wd_period_ms);
        end
        fr(mk(3'h0, 3'h6, {1'b0, ~^8'hE0, 8'hE0}), 1'b0, rx);
        chk("wd_bad_par", 16'h0400, o_wd_period_ms);
        $display("test watchdog done");
    endtask

    task automatic t_diag;
        logic [15:0] rx;
        for (int c = 1; c < 4; c++) begin
            i_rst_code = 2'(c);
            pulse(i_rst_evt);
            chk("rr", 16'(c), o_restart_reason);
        end
        i_lh_code = 3'h5;
        pulse(i_lh_evt);
        fr(mk(3'h7, 3'h7, 10'h000), 1'b1, rx);
        chk("ro_diag", 5'h17, rx[10:6]);
        chk("rr_read", 0, o_restart_reason);
        chk("lc_kept", 5, o_limp_cause);
        chk("ro_sel", `SBC_SEL_DIAG, o_ro_clear_sel);
        pulse(i_rst_evt);
        pulse(i_leave_sleep_fs);
        chk("rr_leave", 0, o_restart_reason);
        i_ce = 1'b0;
        pulse(i_rst_evt);
        chk("ce_hold", 0, o_restart_reason);
        i_ce = 1'b1;
        fr(mk(3'h7, 3'h4, 10'h3FE), 1'b1, rx);
        chk("ro_cfg", 10'h115, rx[15:6]);
        chk("ro_nowrite", SBC_THR_ONE, o_threshold);
        $display("test diagnostics done");
    endtask

    task automatic t_limp;
        logic [15:0] rx;
        for (int c = 1; c < 8; c++) begin
            i_lh_code = 3'(c);
            pulse(i_lh_evt);
            chk("lc", 16'(c), o_limp_cause);
        end
        chk("lh_on", 1, o_limp_home_output);
        fr(mk(3'h0, 3'h4, 10'h115), 1'b1, rx);
        chk("lc_off", 0, o_limp_cause);
        chk("lh_off", 0, o_limp_home_output);
        $display("test limp home done");
    endtask

    task automatic t_first;
        logic [2:0] pm [5] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
        logic pf [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [2:0] sl [5] = '{3'h0, 3'h7, 3'h7, 3'h4, 3'h4};
        logic [15:0] rx;
        i_rst_code = 2'h1;
        pulse(i_rst_evt);
        for (int i = 0; i < 5; i++) begin
            i_prev_mode = pm[i];
            i_prev_fail = pf[i];
            pulse(i_normal_entry);
            fr(mk(3'h0, 3'h5, 10'h000), 1'b1, rx);
            chk("first_hdr", {sl[i], pm[i]}, rx[5:0]);
            if (i == 0)
                chk("first_wake", 10'h2A5, rx[15:6]);
        end
        chk("rr_kept", 1, o_restart_reason);
        chk("wr_frame", mk(3'h0, 3'h5, 10'h000), o_write_frame);
        $display("test first frame done");
    endtask

    task automatic t_fail;
        logic [15:0] rx;
        int r, l, t;
        i_hw_config = 3'h4;
        repeat (4) @(negedge i_clk);
        chk("dev", 1, o_sw_dev_mode);
        t = n_trig;
        fr(mk(3'h7, 3'h7, 10'h000), 1'b1, rx);
        chk("hw_read", 4, rx[13:11]);
        chk("ro_trig", 16'(t + 1), 16'(n_trig));
        r = n_rst;
        pulse(i_wd_fail);
        chk("dev_norst", 16'(r), 16'(n_rst));
        i_hw_config = 3'h0;
        fr(mk(3'h7, 3'h7, 10'h000), 1'b1, rx);
        l = n_limp;
        pulse(i_wd_fail);
        chk("rst", 16'(r + 1), 16'(n_rst));
        chk("limp_1of2", 16'(l), 16'(n_limp));
        pulse(i_wd_fail);
        chk("limp_2of2", 16'(l + 1), 16'(n_limp));
        fr(mk(3'h0, 3'h4, 10'h015), 1'b1, rx);
        fr(mk(3'h7, 3'h7, 10'h000), 1'b1, rx);
        pulse(i_wd_fail);
        chk("limp_1of1", 16'(l + 2), 16'(n_limp));
        $display("test watchdog failure done");
    endtask

    initial begin
        repeat (8) @(negedge i_clk);
        i_srst = 1'b0;
        repeat (4) @(negedge i_clk);
        t_thr();
        t_wd();
        t_diag();
        t_limp();
        t_first();
        t_fail();
        wrap_up();
    end
endmodule
